// ==== hw/sctc_pkg.sv ====
// Purpose: Shared constants of the card timing counters
// Assumes: 8-bit special function register bus
// Notes:   Offsets other than the enable register are local
package sctc_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] SCTC_ADDR_IE   = 8'hAE;
  localparam logic [7:0] SCTC_ADDR_CTRL = 8'hA0;
  localparam logic [7:0] SCTC_ADDR_ETU0 = 8'hA1;
  localparam logic [7:0] SCTC_ADDR_ETU1 = 8'hA2;
  localparam logic [7:0] SCTC_ADDR_GT0  = 8'hA3;
  localparam logic [7:0] SCTC_ADDR_GT1  = 8'hA4;
  localparam logic [7:0] SCTC_ADDR_WT0  = 8'hA5;
  localparam logic [7:0] SCTC_ADDR_WT1  = 8'hA6;
  localparam logic [7:0] SCTC_ADDR_WT2  = 8'hA7;
  localparam logic [7:0] SCTC_ADDR_WT3  = 8'hA9;
  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int SCTC_IE_TXE   = 7;
  localparam int SCTC_IE_OVC   = 5;
  localparam int SCTC_IE_VFLT  = 4;
  localparam int SCTC_IE_WT    = 3;
  localparam int SCTC_IE_SENT  = 2;
  localparam int SCTC_IE_RECV  = 1;
  localparam int SCTC_IE_PAR   = 0;
  localparam int SCTC_CTRL_UART = 0;
  localparam int SCTC_CTRL_WAIT_TIMER_ENABLE = 3;
  localparam int SCTC_ETU_COMP  = 7;
  localparam int SCTC_ETU_W     = 11;
  localparam int SCTC_GT_W      = 9;
  localparam int SCTC_WT_W      = 32;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0]  SCTC_IE_RST   = 8'h00;
  localparam logic [7:0]  SCTC_IE_WMASK = 8'hBF;
  localparam logic [7:0]  SCTC_CTRL_RST = 8'h00;
  localparam logic [10:0] SCTC_ETU_RST  = 11'h174;
  localparam logic [8:0]  SCTC_GT_RST   = 9'h00C;
  localparam logic [7:0]  SCTC_WT_RST   = 8'h00;
  localparam int          SCTC_CARD_DIV = 4;
endpackage : sctc_pkg

// ==== hw/sctc_etu_if.sv ====
// Purpose: Carrier between control and unit divider
// Assumes: Single ref_clk domain
// Notes:   Card tick is an enable, not a clock
`timescale 1ns/1ns
interface sctc_etu_if;
  logic        card_tick;
  logic        char_start;
  logic        comp_en;
  logic [10:0] etu_period;
  logic        shift_en;
  logic        even_bit;
  modport div (input card_tick, input char_start, input comp_en, input etu_period,
               output shift_en, output even_bit);
  modport ctl (output card_tick, output char_start, output comp_en, output etu_period,
               input shift_en, input even_bit);
endinterface : sctc_etu_if

// ==== hw/sctc_etu_div.sv ====
// Purpose: Elementary time unit divider with compensation
// Assumes: card_tick is one ref_clk cycle per card clock
// Notes:   Bit 0 of a character (start bit) counts as even
`timescale 1ns/1ns
module sctc_etu_div
  import sctc_pkg::*;
#(
  parameter int ETU_W = SCTC_ETU_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sctc_etu_if.div  u
);
  logic [ETU_W-1:0] cnt_r;
  logic [3:0]       bit_idx_r;
  logic [ETU_W-1:0] period_nxt;
  logic             next_even;

  // Next bit is even when the current index is odd; a new character opens on even bit 0
  assign next_even = u.char_start || bit_idx_r[0];
  // Compensation shortens even bits by one card clock
  always_comb begin
    period_nxt = u.etu_period;
    if (u.comp_en && next_even && u.etu_period > 11'h001) begin
      period_nxt = u.etu_period - 11'h001;
    end
  end

  // ----------------------------------------
  // Unit counter, reloads on every expiry
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r      <= SCTC_ETU_RST;
      u.shift_en <= 1'b0;
    end else if (u.char_start) begin
      cnt_r      <= period_nxt;
      u.shift_en <= 1'b0;
    end else begin
      u.shift_en <= 1'b0;
      if (u.card_tick) begin
        if (cnt_r <= 11'h001) begin
          cnt_r      <= period_nxt;
          u.shift_en <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 11'h001;
        end
      end
    end
  end

  // Bit position inside the character
  always_ff @(posedge ref_clk) begin
    if (sys_rst || u.char_start) begin
      bit_idx_r  <= 4'h0;
      u.even_bit <= 1'b1;
    end else if (u.shift_en) begin
      bit_idx_r  <= bit_idx_r + 4'h1;
      u.even_bit <= bit_idx_r[0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_shift_single;
    @(posedge ref_clk) disable iff (sys_rst) u.shift_en |=> !u.shift_en;
  endproperty
  a_shift_single: assert property (p_shift_single) else $error("shift enable longer than one cycle");
  property p_comp_even;
    @(posedge ref_clk) disable iff (sys_rst)
      (u.card_tick && cnt_r <= 11'h001 && !u.char_start && u.comp_en && next_even
       && u.etu_period > 11'h001) |=> cnt_r == u.etu_period - 11'h001;
  endproperty
  a_comp_even: assert property (p_comp_even) else $error("even bit not shortened");
  property p_comp_start;
    @(posedge ref_clk) disable iff (sys_rst)
      (u.char_start && u.comp_en && u.etu_period > 11'h001) |=> cnt_r == $past(u.etu_period) - 11'h001;
  endproperty
  a_comp_start: assert property (p_comp_start) else $error("start bit not shortened");
endmodule : sctc_etu_div

// ==== hw/sctc_timing.sv ====
// Purpose: Card interface timing counters and interrupt gating
// Assumes: Register bus is the 8-bit special function bus
// Notes:   Card clock is a tick enable from a ref_clk divider
//
// How it works
// - 11-bit unit counter makes shifter enable
// - Compensation bit shortens even bits by one
// - Guard counter spaces transmitted start edges
// - Guard counter 9 bits, wait counter 32
// - Wait expiry interrupts and locks interface
// - Only reset or reload releases lock
// - Enable low: byte2 write loads counter
// - Enable high, character mode: reload on start
// - Enable rising starts, falling stops counter
// - Enable bit 7 gates buffer empty
// - Enable bit 5 gates overcurrent
// - Enable bit 4 gates voltage fault
// - Enable bit 3 gates wait timeout
// - Enable bit 2 gates character sent
// - Enable bit 1 gates character received
// - Enable bit 0 gates parity fault
// - Enable register needs bank one, resets zero
`timescale 1ns/1ns
module sctc_timing
  import sctc_pkg::*;
#(
  parameter int CARD_DIV = SCTC_CARD_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       register_bank_select,
  input  wire logic       card_iface_reset,
  input  wire logic       char_start,
  input  wire logic       start_bit_det,
  input  wire logic       tx_start_req,
  input  wire logic       tx_buf_empty_evt,
  input  wire logic       overcurrent_evt,
  input  wire logic       voltage_fault_evt,
  input  wire logic       char_sent_evt,
  input  wire logic       char_recv_evt,
  input  wire logic       parity_fault_evt,
  output logic            shift_en,
  output logic            tx_start_ok,
  output logic            rx_allowed,
  output logic            iface_locked,
  output logic      [7:0] irq_req
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCTC_WT_IDLE = 3'b001,
    SCTC_WT_RUN  = 3'b010,
    SCTC_WT_EXP  = 3'b100
  } sctc_wt_e;

  sctc_etu_if etu ();

  logic [7:0]            ie_r;
  logic [7:0]            ctrl_r;
  logic [SCTC_ETU_W-1:0] etu_r;
  logic                  comp_r;
  logic [SCTC_GT_W-1:0]  gt_r;
  logic [7:0]            wt_hold_r [4];
  logic [SCTC_WT_W-1:0]  wt_cnt_r;
  logic [SCTC_GT_W-1:0]  gt_cnt_r;
  sctc_wt_e              wt_st_r;
  logic                  wait_timer_enable_q_r;
  logic                  wt_flag_r;
  logic                  lock_r;
  logic [7:0]            div_cnt_r;
  logic                  card_tick_r;
  logic [7:0]            evt_vec;
  logic                  wait_timer_enable;
  logic                  uart_mode;
  logic                  ie_sel;
  logic                  manual_load;
  logic                  auto_load;
  logic                  wt_reload;
  logic                  wt_expire;
  logic                  tx_taken;
  logic [SCTC_WT_W-1:0]  wt_hold_word;

  // Decodes one address, the enable register needs bank one
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  assign wait_timer_enable         = ctrl_r[SCTC_CTRL_WAIT_TIMER_ENABLE];
  assign uart_mode    = ctrl_r[SCTC_CTRL_UART];
  assign ie_sel       = hit(sfr_addr, SCTC_ADDR_IE) && register_bank_select;
  assign wt_hold_word = {wt_hold_r[3], wt_hold_r[2], wt_hold_r[1], wt_hold_r[0]};
  // Manual load only while the enable is low
  assign manual_load  = sfr_wr && hit(sfr_addr, SCTC_ADDR_WT2) && !wait_timer_enable;
  assign auto_load    = wait_timer_enable && uart_mode && start_bit_det;
  assign wt_reload    = manual_load || auto_load;
  assign wt_expire    = (wt_st_r == SCTC_WT_RUN) && etu.shift_en && wt_cnt_r <= 32'h0000_0001;
  assign tx_taken     = tx_start_req && tx_start_ok;

  // ----------------------------------------
  // Card clock tick divider
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt_r   <= 8'h00;
      card_tick_r <= 1'b0;
    end else if (div_cnt_r >= 8'(CARD_DIV - 1)) begin
      div_cnt_r   <= 8'h00;
      card_tick_r <= 1'b1;
    end else begin
      div_cnt_r   <= div_cnt_r + 8'h01;
      card_tick_r <= 1'b0;
    end
  end

  // Unit divider hookup
  assign etu.card_tick  = card_tick_r;
  assign etu.char_start = char_start;
  assign etu.comp_en    = comp_r;
  assign etu.etu_period = etu_r;
  assign shift_en       = etu.shift_en;

  sctc_etu_div #(
    .ETU_W (SCTC_ETU_W)
  ) u_etu (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .u       (etu.div)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Interrupt enables; reserved bit 6 keeps its reset value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ie_r <= SCTC_IE_RST;
    end else if (sfr_wr && ie_sel) begin
      ie_r <= sfr_wdata & SCTC_IE_WMASK;
    end
  end

  // Control register carries the wait enable and mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= SCTC_CTRL_RST;
    end else if (sfr_wr && hit(sfr_addr, SCTC_ADDR_CTRL)) begin
      ctrl_r <= sfr_wdata;
    end
  end

  // Unit period and compensation bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      etu_r  <= SCTC_ETU_RST;
      comp_r <= 1'b0;
    end else if (sfr_wr && hit(sfr_addr, SCTC_ADDR_ETU0)) begin
      etu_r[7:0] <= sfr_wdata;
    end else if (sfr_wr && hit(sfr_addr, SCTC_ADDR_ETU1)) begin
      etu_r[10:8] <= sfr_wdata[2:0];
      comp_r      <= sfr_wdata[SCTC_ETU_COMP];
    end
  end

  // Guard time value, 9 bits over two bytes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gt_r <= SCTC_GT_RST;
    end else if (sfr_wr && hit(sfr_addr, SCTC_ADDR_GT0)) begin
      gt_r[7:0] <= sfr_wdata;
    end else if (sfr_wr && hit(sfr_addr, SCTC_ADDR_GT1)) begin
      gt_r[8] <= sfr_wdata[0];
    end
  end

  // Wait holding bytes; they stay for the automatic reloads
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        wt_hold_r[i] <= SCTC_WT_RST;
      end
    end else if (sfr_wr) begin
      if (hit(sfr_addr, SCTC_ADDR_WT0)) wt_hold_r[0] <= sfr_wdata;
      if (hit(sfr_addr, SCTC_ADDR_WT1)) wt_hold_r[1] <= sfr_wdata;
      if (hit(sfr_addr, SCTC_ADDR_WT2)) wt_hold_r[2] <= sfr_wdata;
      if (hit(sfr_addr, SCTC_ADDR_WT3)) wt_hold_r[3] <= sfr_wdata;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Unmapped addresses and the enable register in bank zero read as zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (ie_sel) sfr_rdata <= ie_r;
      else if (hit(sfr_addr, SCTC_ADDR_CTRL)) sfr_rdata <= ctrl_r;
      else if (hit(sfr_addr, SCTC_ADDR_ETU0)) sfr_rdata <= etu_r[7:0];
      else if (hit(sfr_addr, SCTC_ADDR_ETU1)) sfr_rdata <= {comp_r, 4'h0, etu_r[10:8]};
      else if (hit(sfr_addr, SCTC_ADDR_GT0)) sfr_rdata <= gt_r[7:0];
      else if (hit(sfr_addr, SCTC_ADDR_GT1)) sfr_rdata <= {7'h00, gt_r[8]};
      else if (hit(sfr_addr, SCTC_ADDR_WT0)) sfr_rdata <= wt_hold_r[0];
      else if (hit(sfr_addr, SCTC_ADDR_WT1)) sfr_rdata <= wt_hold_r[1];
      else if (hit(sfr_addr, SCTC_ADDR_WT2)) sfr_rdata <= wt_hold_r[2];
      else if (hit(sfr_addr, SCTC_ADDR_WT3)) sfr_rdata <= wt_hold_r[3];
      else sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Guard time counter
  // ----------------------------------------
  // Loads at each taken start edge, counts down per unit
  always_ff @(posedge ref_clk) begin
    if (sys_rst || card_iface_reset) begin
      gt_cnt_r <= 9'h000;
    end else if (tx_taken) begin
      gt_cnt_r <= gt_r;
    end else if (etu.shift_en && gt_cnt_r != 9'h000) begin
      gt_cnt_r <= gt_cnt_r - 9'h001;
    end
  end

  // Start allowed once guard elapsed and not locked
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_start_ok <= 1'b0;
      rx_allowed  <= 1'b0;
    end else begin
      tx_start_ok <= !tx_taken && gt_cnt_r == 9'h000 && !lock_r
                     && !(wt_expire && !wt_reload);
      rx_allowed  <= !lock_r && !(wt_expire && !wt_reload);
    end
  end

  // ----------------------------------------
  // Waiting time counter
  // ----------------------------------------
  // Enable edge detector, same-domain register bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_timer_enable_q_r <= 1'b0;
    end else begin
      wait_timer_enable_q_r <= wait_timer_enable;
    end
  end

  // Run state follows the enable edges and expiry
  always_ff @(posedge ref_clk) begin
    if (sys_rst || card_iface_reset) begin
      wt_st_r <= SCTC_WT_IDLE;
    end else begin
      unique case (wt_st_r)
        SCTC_WT_IDLE: begin
          if ((wait_timer_enable && !wait_timer_enable_q_r) || auto_load) wt_st_r <= SCTC_WT_RUN;
        end
        SCTC_WT_RUN: begin
          if (!wait_timer_enable) wt_st_r <= SCTC_WT_IDLE;
          else if (auto_load) wt_st_r <= SCTC_WT_RUN;
          else if (wt_expire) wt_st_r <= SCTC_WT_EXP;
        end
        SCTC_WT_EXP: begin
          if (!wait_timer_enable) wt_st_r <= SCTC_WT_IDLE;
          else if (auto_load) wt_st_r <= SCTC_WT_RUN;
        end
        default: wt_st_r <= SCTC_WT_IDLE;
      endcase
    end
  end

  // Counts units down while running; reload beats count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wt_cnt_r <= 32'h0000_0000;
    end else if (manual_load) begin
      wt_cnt_r <= {wt_hold_r[3], sfr_wdata, wt_hold_r[1], wt_hold_r[0]};
    end else if (auto_load) begin
      wt_cnt_r <= wt_hold_word;
    end else if (wt_st_r == SCTC_WT_RUN && etu.shift_en) begin
      wt_cnt_r <= (wt_cnt_r <= 32'h0000_0001) ? 32'h0000_0000 : wt_cnt_r - 32'h0000_0001;
    end
  end

  // Lock and timeout flag; expiry wins over a same-cycle interface reset, a same-cycle reload wins over expiry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_r    <= 1'b0;
      wt_flag_r <= 1'b0;
    end else if (wt_expire && !wt_reload) begin
      lock_r    <= 1'b1;
      wt_flag_r <= 1'b1;
    end else if (card_iface_reset || wt_reload) begin
      lock_r    <= 1'b0;
      wt_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      iface_locked <= 1'b0;
    end else begin
      iface_locked <= (lock_r && !(card_iface_reset || wt_reload)) || (wt_expire && !wt_reload);
    end
  end

  // ----------------------------------------
  // Interrupt request gating
  // ----------------------------------------
  assign evt_vec[SCTC_IE_TXE]  = tx_buf_empty_evt;
  assign evt_vec[6]            = 1'b0;
  assign evt_vec[SCTC_IE_OVC]  = overcurrent_evt;
  assign evt_vec[SCTC_IE_VFLT] = voltage_fault_evt;
  assign evt_vec[SCTC_IE_WT]   = wt_flag_r;
  assign evt_vec[SCTC_IE_SENT] = char_sent_evt;
  assign evt_vec[SCTC_IE_RECV] = char_recv_evt;
  assign evt_vec[SCTC_IE_PAR]  = parity_fault_evt;

  // Each request is its flag masked by its enable bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_req <= 8'h00;
    end else begin
      irq_req <= evt_vec & ie_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_lock_expire;
    wt_expire && !wt_reload |=> lock_r && wt_flag_r && !rx_allowed;
  endproperty
  a_lock_expire: assert property (p_lock_expire) else $error("expiry did not lock");

  property p_lock_hold;
    lock_r && !card_iface_reset && !wt_reload |=> lock_r;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock released without reload");

  property p_manual_load;
    manual_load |=> wt_cnt_r == {$past(wt_hold_r[3]), $past(sfr_wdata), $past(wt_hold_r[1]),
                    $past(wt_hold_r[0])};
  endproperty
  a_manual_load: assert property (p_manual_load) else $error("manual load wrong");

  property p_auto_reload;
    auto_load && !sfr_wr && !card_iface_reset |=> wt_cnt_r == $past(wt_hold_word) && wt_st_r == SCTC_WT_RUN;
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("start bit reload missed");

  property p_stop_fall;
    !wait_timer_enable && wait_timer_enable_q_r && !card_iface_reset |=> wt_st_r == SCTC_WT_IDLE;
  endproperty
  a_stop_fall: assert property (p_stop_fall) else $error("falling enable did not stop");

  sequence s_tx_taken;
    tx_taken && gt_r != 9'h000;
  endsequence
  property p_guard;
    s_tx_taken |=> !tx_start_ok ##1 !tx_start_ok;
  endproperty
  a_guard: assert property (p_guard) else $error("start allowed inside guard time");

  property p_irq_gate;
    ##1 (irq_req & ~$past(ie_r)) == 8'h00 && (irq_req & ~$past(evt_vec)) == 8'h00;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without flag and enable");

  property p_bank_sel;
    sfr_rd && hit(sfr_addr, SCTC_ADDR_IE) && !register_bank_select |=> sfr_rdata == 8'h00;
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("enable register seen in bank zero");

  property p_rsvd_zero;
    ie_r[6] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved enable bit changed");

  property p_wt_irq;
    wt_expire && !wt_reload && ie_r[SCTC_IE_WT] && !(sfr_wr && ie_sel) |=> ##1 irq_req[SCTC_IE_WT];
  endproperty
  a_wt_irq: assert property (p_wt_irq) else $error("timeout request missing");
endmodule : sctc_timing

// ==== sim/sctc_card_model.sv ====
// Purpose: Card side source of start bits for the wait timer
// Assumes: The card answers in whole units of shift_en
// Notes:   A gap of zero keeps the card silent
`timescale 1ns/1ns
module sctc_card_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       shift_en,
  input  wire logic [3:0] gap,
  output logic            start_bit_det
);
  logic [3:0] cnt_r;
  // ----------------------------------------
  // Character pacing
  // ----------------------------------------
  // Small gap answers promptly, large gap lets the wait timer run out
  always_ff @(posedge ref_clk) begin
    start_bit_det <= 1'b0;
    if (sys_rst || gap == 4'h0) begin
      cnt_r <= 4'h0;
    end else if (shift_en) begin
      cnt_r         <= (cnt_r + 4'h1 >= gap) ? 4'h0 : cnt_r + 4'h1;
      start_bit_det <= (cnt_r + 4'h1 >= gap);
    end
  end
endmodule : sctc_card_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the card timing counters
// Assumes: Card divider of two and a five clock unit
// Notes:   Inputs move on the falling edge; checks sample there too
`timescale 1ns/1ns
module tb_top;
  import sctc_pkg::*;
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic       ref_clk, sys_rst, sfr_wr, sfr_rd, bank, ifrst, chs, txr;
  logic [7:0] addr, wdata, rdata, evt, irq, ie, rv;
  logic       sh, tok, rxa, lck, sbd;
  logic [3:0] gap;
  int         fails, checks_done, cyc, n, g, k, p0, p1, i;
  // ----------------------------------------
  // Design, card model, clock and watchdog
  // ----------------------------------------
  sctc_timing #(.CARD_DIV(2)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(rdata), .register_bank_select(bank), .card_iface_reset(ifrst),
    .char_start(chs), .start_bit_det(sbd), .tx_start_req(txr), .tx_buf_empty_evt(evt[7]),
    .overcurrent_evt(evt[5]), .voltage_fault_evt(evt[4]), .char_sent_evt(evt[2]),
    .char_recv_evt(evt[1]), .parity_fault_evt(evt[0]), .shift_en(sh), .tx_start_ok(tok),
    .rx_allowed(rxa), .iface_locked(lck), .irq_req(irq));
  sctc_card_model card_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .shift_en(sh), .gap(gap),
    .start_bit_det(sbd));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Cuts a hang short; ceiling well above the planned run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr   = a;
    wdata  = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr
  // Data is settled one cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    addr   = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    rv = rdata;
  endtask : rd
  task automatic unit();
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sh !== 1'b1 && n < 5000);
  endtask : unit
  // Counts units until the guard opens or the lock sets
  task automatic count_until(input bit want_tok);
    g = 0;
    for (k = 0; k < 3000; k++) begin
      @(negedge ref_clk);
      if (sh === 1'b1) g++;
      if ((want_tok ? tok : lck) === 1'b1) break;
    end
  endtask : count_until
  function automatic logic [7:0] exp_irq(input logic [7:0] en, input logic [7:0] ev, input logic wt);
    exp_irq = en & {ev[7], 1'b0, ev[5:4], wt, ev[2:0]};
  endfunction : exp_irq
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    {sfr_wr, sfr_rd, bank, ifrst, chs, txr} = 6'h00;
    {addr, wdata, evt, gap} = 28'h000_0000;
    void'($urandom(32'hadd7_430f));
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    `CHK({lck, irq}, 9'h000)
    // Bank gating, reserved bit, unmapped place
    rd(SCTC_ADDR_IE);
    `CHK(rv, 8'h00)
    bank = 1'b1;
    rd(SCTC_ADDR_IE);
    `CHK(rv, 8'h00)
    wr(SCTC_ADDR_IE, 8'hFF);
    bank = 1'b0;
    wr(SCTC_ADDR_IE, 8'h00);
    bank = 1'b1;
    rd(SCTC_ADDR_IE);
    `CHK(rv, 8'hBF)
    rd(8'hFE);
    `CHK(rv, 8'h00)
    $display("test registers done");
    // Random enables against random events, all-set and all-clear first
    for (i = 0; i < 16; i++) begin
      ie  = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      evt = (i < 2) ? 8'hFF : 8'($urandom);
      wr(SCTC_ADDR_IE, ie);
      repeat (2) @(negedge ref_clk);
      `CHK(irq, exp_irq(ie, evt, 1'b0))
    end
    evt = 8'h00;
    $display("test interrupt gating done");
    // Unit of five card clocks, then compensation after a character start
    wr(SCTC_ADDR_ETU0, 8'h05);
    wr(SCTC_ADDR_ETU1, 8'h00);
    unit();
    unit();
    `CHK(n, 10)
    @(negedge ref_clk);
    `CHK(sh, 1'b0)
    wr(SCTC_ADDR_ETU1, 8'h80);
    unit();
    chs = 1'b1;
    @(negedge ref_clk);
    chs = 1'b0;
    unit();
    `CHK(n, 7)
    unit();
    p0 = n;
    unit();
    p1 = n;
    `CHK(p0 + p1, 18)
    `CHK(p0 != p1, 1'b1)
    wr(SCTC_ADDR_ETU1, 8'h00);
    $display("test unit counter done");
    // Guard of three units between start edges
    wr(SCTC_ADDR_GT0, 8'h03);
    wr(SCTC_ADDR_GT1, 8'h00);
    count_until(1'b1);
    unit();
    txr = 1'b1;
    @(negedge ref_clk);
    txr = 1'b0;
    `CHK(tok, 1'b0)
    count_until(1'b1);
    `CHK(g, 3)
    $display("test guard done");
    // Manual wait timer of 258 units; byte 2 write loads the word
    wr(SCTC_ADDR_IE, 8'h08);
    // Stale byte 2 must not leak into the loaded word
    wr(SCTC_ADDR_WT2, 8'h01);
    wr(SCTC_ADDR_WT0, 8'h02);
    wr(SCTC_ADDR_WT1, 8'h01);
    wr(SCTC_ADDR_WT3, 8'h00);
    wr(SCTC_ADDR_WT2, 8'h00);
    unit();
    wr(SCTC_ADDR_CTRL, 8'h08);
    count_until(1'b0);
    `CHK(g, 258)
    @(negedge ref_clk);
    `CHK({lck, rxa, tok, irq}, {3'b100, exp_irq(8'h08, 8'h00, 1'b1)})
    wr(SCTC_ADDR_IE, 8'h00);
    wr(SCTC_ADDR_CTRL, 8'h00);
    repeat (30) @(negedge ref_clk);
    `CHK({lck, irq[3]}, 2'b10)
    // Software restart: enable low, rewrite byte 2, enable high
    wr(SCTC_ADDR_WT2, 8'h00);
    repeat (2) @(negedge ref_clk);
    `CHK(lck, 1'b0)
    wr(SCTC_ADDR_CTRL, 8'h08);
    count_until(1'b0);
    ifrst = 1'b1;
    @(negedge ref_clk);
    ifrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK({lck, rxa}, 2'b01)
    // Falling enable stops the count before it runs out
    wr(SCTC_ADDR_CTRL, 8'h00);
    wr(SCTC_ADDR_WT2, 8'h00);
    wr(SCTC_ADDR_CTRL, 8'h08);
    repeat (5) unit();
    wr(SCTC_ADDR_CTRL, 8'h00);
    repeat (300) unit();
    `CHK(lck, 1'b0)
    $display("test manual wait timer done");
    // Character mode: prompt card keeps reloading four units, slow card times out
    wr(SCTC_ADDR_WT0, 8'h04);
    wr(SCTC_ADDR_WT1, 8'h00);
    wr(SCTC_ADDR_WT2, 8'h00);
    gap = 4'h3;
    wr(SCTC_ADDR_CTRL, 8'h09);
    repeat (40) unit();
    `CHK(lck, 1'b0)
    gap = 4'h6;
    // Slow card: count runs out after the last reload, the next start releases
    count_until(1'b0);
    `CHK(lck, 1'b1)
    `CHK(g, 3)
    repeat (3) unit();
    `CHK(lck, 1'b0)
    $display("test character mode done");
    end_of_test();
  end
endmodule : tb_top
